/* logic/can_bias_pkg.sv */
// Package with shared types and constants for the CAN bus-bias state control.
package can_bias_pkg;

   // Bias states of the bus.
   typedef enum logic [1:0] {
      BIAS_OFF,
      BIAS_AUTO_INACTIVE,
      BIAS_AUTO_ACTIVE,
      BIAS_ACTIVE
   } bias_state_e;

   // Operating modes selected by the mode logic outside this block.
   typedef enum logic [2:0] {
      MODE_NORMAL,
      MODE_SILENT,
      MODE_STANDBY,
      MODE_GO_TO_SLEEP,
      MODE_SLEEP
   } op_mode_e;

   // Supply monitor flags, all active high.
   typedef struct packed {
      logic battery_uv_falling;
      logic battery_uv_rising;
      logic core_supply_uv_falling;
      logic core_supply_uv_rising;
      logic io_supply_uv_falling;
      logic io_supply_uv_rising;
   } supply_flags_s;

   // Bus pin controls: output enables are high while the block drives.
   typedef struct packed {
      logic canh_o;
      logic canh_oe;
      logic canl_o;
      logic canl_oe;
      logic bias_mid;
      logic bias_gnd;
      logic bias_float;
   } bus_drive_s;

   // Clock rate and silence time.
   localparam int CLK_FREQ_HZ = 25_000_000;
   localparam int BUS_IDLE_TIMEOUT_US = 1000;
   localparam longint BUS_IDLE_TIMEOUT_CYC_L =
      (longint'(BUS_IDLE_TIMEOUT_US) * CLK_FREQ_HZ) / 1_000_000;
   localparam int BUS_IDLE_TIMEOUT_CYC = int'(BUS_IDLE_TIMEOUT_CYC_L);
   localparam int IDLE_CNT_W = 16;

   // Receive sample FIFO.
   localparam int RX_FIFO_WIDTH = 1;
   localparam int RX_FIFO_DEPTH = 4;

   // Reset values.
   localparam logic RXD_RESET = 1'b1;
   localparam logic [15:0] IDLE_CNT_RESET = 16'h0000;

endpackage : can_bias_pkg

/* logic/sample_fifo.sv */
// Small valid/ready FIFO for the receive path samples.
`timescale 1ns/1ps
module sample_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 4
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   // Whole FIFO state in one packed struct.
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
   } fifo_state_s;

   fifo_state_s st_r;
   fifo_state_s st_nxt;
   logic push;
   logic pop;

   assign in_ready_o = (st_r.count != (AW+1)'(DEPTH));
   assign out_valid_o = (st_r.count != '0);
   assign out_data_o = st_r.mem[st_r.rd_ptr];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Pointer and count update; a push and pop together leave count unchanged.
   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wr_ptr] = in_data_i;
         st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
      end
      if (pop) begin
         st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         st_nxt.count = st_r.count + 1'b1;
      end else if (pop && !push) begin
         st_nxt.count = st_r.count - 1'b1;
      end
   end

   // State register.
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule : sample_fifo

/* logic/can_bias_state_control.sv */
// Bus-bias state machine, driver and receiver mapping of a CAN transceiver.
//
// What this block does
// - Battery falling undervoltage forces the off state, bus floating.
// - Off goes to autonomous inactive when battery rises above threshold.
// - Autonomous inactive biases both bus pins to ground.
// - Remote wake in autonomous inactive biases bus mid and enters autonomous active.
// - Without normal or silent mode before idle timeout, fall back to autonomous inactive.
// - Normal/silent to low power: active if idle short, else inactive.
// - Active goes autonomous active on core/io falling flag or short-idle low power.
// - Inactive goes autonomous active on wake or normal/silent with supply undervoltage.
// - Autonomous active returns inactive in low power after idle timeout.
// - Active entered only in normal mode with core and io supplies good.
// - Normal runs driver and receiver; silent disables driver only.
// - Transmit low before leaving standby blocks the transmitter in active.
// - Normal: low transmit drives dominant; receive low while bus dominant.
// - High transmit leaves bus recessive, driver off; receive high when recessive.
// - Silent, standby and sleep keep both bus outputs high impedance.
// - Standby/sleep receive high unless wake persists; tri-state without supplies.
// - Wake receiver replaces normal receiver in sleep and go-to-sleep.
// - Active state biases the bus at half the core supply.
// - Remote wake taken on rising edge of the synchronised wake pattern input.
`timescale 1ns/1ps
module can_bias_state_control
   import can_bias_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [2:0] op_mode_i,
   input wire supply_flags_s supply_i,
   input wire logic txd_i,
   input wire logic bus_dominant_i,
   input wire logic remote_wake_pattern_i,
   input wire logic vsup_present_i,
   input wire logic vio_present_i,
   output bias_state_e bias_state_o,
   output bus_drive_s bus_o,
   output logic rxd_o,
   output logic rxd_oe_o,
   output logic tx_stuck_low_block_o,
   output logic wake_rx_active_o,
   output logic bus_idle_timeout_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers: every pin passes two flops before any logic.

   typedef struct packed {
      logic [2:0] mode;
      supply_flags_s sup;
      logic txd;
      logic dom;
      logic wake;
      logic vsup;
      logic vio;
   } pin_s;

   pin_s pins_in;
   pin_s meta_r;
   pin_s sync_r;

   assign pins_in = '{mode: op_mode_i, sup: supply_i, txd: txd_i, dom: bus_dominant_i,
                      wake: remote_wake_pattern_i, vsup: vsup_present_i,
                      vio: vio_present_i};

   // Two-stage synchroniser; the first stage feeds only the second.
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= pins_in;
         sync_r <= meta_r;
      end
   end

   op_mode_e mode;
   logic low_power;
   logic act_mode;
   logic uv_falling_any;
   logic supplies_good;

   assign mode = op_mode_e'(sync_r.mode);
   assign low_power = (mode == MODE_STANDBY) || (mode == MODE_GO_TO_SLEEP) ||
                      (mode == MODE_SLEEP);
   assign act_mode = (mode == MODE_NORMAL) || (mode == MODE_SILENT);
   assign uv_falling_any = sync_r.sup.core_supply_uv_falling ||
                           sync_r.sup.io_supply_uv_falling;
   assign supplies_good = sync_r.sup.core_supply_uv_rising &&
                          sync_r.sup.io_supply_uv_rising && !uv_falling_any;

   ////////////////////////////////////////////////////////////////////////////
   // Receive sample FIFO: samples of the bus pass through it to the rxd flop.

   logic fifo_in_ready;
   logic [0:0] fifo_out_data;
   logic fifo_out_valid;

   sample_fifo #(
      .WIDTH(RX_FIFO_WIDTH),
      .DEPTH(RX_FIFO_DEPTH)
   ) u_rx_fifo (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .in_data_i(sync_r.dom),
      .in_valid_i(1'b1),
      .in_ready_o(fifo_in_ready),
      .out_data_o(fifo_out_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(1'b1)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Block state, one packed struct.

   typedef struct packed {
      bias_state_e state;
      logic [IDLE_CNT_W-1:0] idle_cnt;
      logic timeout;
      logic [2:0] prev_mode;
      logic txd_low_seen;
      logic tx_block;
      logic wake_hold;
      logic prev_wake;
      logic rx_dom;
      bus_drive_s bus;
      logic rxd;
      logic rxd_oe;
      logic wake_rx;
   } blk_s;

   blk_s st_r;
   blk_s st_nxt;
   logic mode_to_low;
   logic wake_event;

   assign mode_to_low = low_power && ((op_mode_e'(st_r.prev_mode) == MODE_NORMAL) ||
                                      (op_mode_e'(st_r.prev_mode) == MODE_SILENT));
   // Wake is taken on the rising edge of the synchronised pattern flag.
   assign wake_event = sync_r.wake && !st_r.prev_wake;

   // Next-state logic for timer, bias state, driver and receiver.
   always_comb begin
      st_nxt = st_r;
      st_nxt.prev_mode = sync_r.mode;
      st_nxt.prev_wake = sync_r.wake;
      if (fifo_out_valid) begin
         st_nxt.rx_dom = fifo_out_data[0];
      end

      // Idle timer: any dominant restarts it, saturating flag on expiry.
      if (sync_r.dom) begin
         st_nxt.idle_cnt = '0;
         st_nxt.timeout = 1'b0;
      end else if (st_r.idle_cnt >= IDLE_CNT_W'(BUS_IDLE_TIMEOUT_CYC)) begin
         st_nxt.timeout = 1'b1;
      end else begin
         st_nxt.idle_cnt = st_r.idle_cnt + 1'b1;
      end

      // Stuck-low transmit capture while in standby, before leaving it.
      if (mode == MODE_STANDBY) begin
         st_nxt.txd_low_seen = !sync_r.txd;
      end

      // Wake latch persists until normal or silent mode is entered.
      if (wake_event) begin
         st_nxt.wake_hold = 1'b1;
      end else if (act_mode) begin
         st_nxt.wake_hold = 1'b0;
      end

      // Bias state machine. Battery loss dominates every other condition.
      if (sync_r.sup.battery_uv_falling) begin
         st_nxt.state = BIAS_OFF;
      end else begin
         case (st_r.state)
            BIAS_OFF: begin
               if (sync_r.sup.battery_uv_rising) begin
                  st_nxt.state = BIAS_AUTO_INACTIVE;
               end
            end
            BIAS_AUTO_INACTIVE: begin
               if ((mode == MODE_NORMAL) && supplies_good) begin
                  st_nxt.state = BIAS_ACTIVE;
                  // The capture is used once, so a later supply dip cannot re-block.
                  st_nxt.tx_block = st_r.txd_low_seen;
                  st_nxt.txd_low_seen = 1'b0;
               end else if (wake_event || (act_mode && uv_falling_any)) begin
                  st_nxt.state = BIAS_AUTO_ACTIVE;
               end
            end
            BIAS_AUTO_ACTIVE: begin
               if ((mode == MODE_NORMAL) && supplies_good) begin
                  st_nxt.state = BIAS_ACTIVE;
                  st_nxt.tx_block = st_r.txd_low_seen;
                  st_nxt.txd_low_seen = 1'b0;
               end else if (low_power && st_r.timeout) begin
                  st_nxt.state = BIAS_AUTO_INACTIVE;
               end
            end
            BIAS_ACTIVE: begin
               if (uv_falling_any) begin
                  st_nxt.state = BIAS_AUTO_ACTIVE;
               end else if (mode_to_low) begin
                  // Short idle keeps bias up, long idle drops it.
                  st_nxt.state = st_r.timeout ? BIAS_AUTO_INACTIVE
                                              : BIAS_AUTO_ACTIVE;
               end
            end
            default: st_nxt.state = BIAS_OFF;
         endcase
      end
      if (st_nxt.state != BIAS_ACTIVE) begin
         st_nxt.tx_block = 1'b0;
      end

      // Bias selection per state.
      st_nxt.bus.bias_float = (st_nxt.state == BIAS_OFF);
      st_nxt.bus.bias_gnd = (st_nxt.state == BIAS_AUTO_INACTIVE);
      st_nxt.bus.bias_mid = (st_nxt.state == BIAS_AUTO_ACTIVE) ||
                            (st_nxt.state == BIAS_ACTIVE);

      // Driver: only normal mode in active state with no block drives dominant.
      st_nxt.bus.canh_o = 1'b1;
      st_nxt.bus.canl_o = 1'b0;
      st_nxt.bus.canh_oe = (st_nxt.state == BIAS_ACTIVE) && (mode == MODE_NORMAL) &&
                           !st_nxt.tx_block && !sync_r.txd;
      st_nxt.bus.canl_oe = st_nxt.bus.canh_oe;

      // Receiver: full receiver in normal/silent, wake latch on rxd otherwise; wake receiver flag in sleep and go-to-sleep only.
      st_nxt.wake_rx = (mode == MODE_SLEEP) || (mode == MODE_GO_TO_SLEEP);
      if (act_mode) begin
         st_nxt.rxd = !st_r.rx_dom;
         st_nxt.rxd_oe = sync_r.vio;
      end else begin
         st_nxt.rxd = !st_r.wake_hold;
         st_nxt.rxd_oe = sync_r.vio && sync_r.vsup;
      end
   end

   // State register.
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r <= '0;
         st_r.rxd <= RXD_RESET;
         st_r.idle_cnt <= IDLE_CNT_RESET;
         st_r.bus.bias_float <= 1'b1;
         st_r.bus.canh_o <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs come straight from the state flops.
   assign bias_state_o = st_r.state;
   assign bus_o = st_r.bus;
   assign rxd_o = st_r.rxd;
   assign rxd_oe_o = st_r.rxd_oe;
   assign tx_stuck_low_block_o = st_r.tx_block;
   assign wake_rx_active_o = st_r.wake_rx;
   assign bus_idle_timeout_o = st_r.timeout;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   chk_off_on_batt: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      sync_r.sup.battery_uv_falling |=> (st_r.state == BIAS_OFF) && st_r.bus.bias_float)
      else $error("battery loss did not force off state");

   chk_off_exit: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st_r.state == BIAS_OFF) && !sync_r.sup.battery_uv_falling &&
      sync_r.sup.battery_uv_rising |=> (st_r.state == BIAS_AUTO_INACTIVE))
      else $error("off state not left on battery recovery");

   chk_inactive_gnd: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st_r.state == BIAS_AUTO_INACTIVE) |-> st_r.bus.bias_gnd && !st_r.bus.bias_mid)
      else $error("inactive state not ground biased");

   chk_wake_active: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st_r.state == BIAS_AUTO_INACTIVE) && wake_event && !sync_r.sup.battery_uv_falling &&
      !((mode == MODE_NORMAL) && supplies_good) |=> (st_r.state == BIAS_AUTO_ACTIVE))
      else $error("wake did not raise bias");

   chk_timeout_drop: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st_r.state == BIAS_AUTO_ACTIVE) && low_power && st_r.timeout &&
      !sync_r.sup.battery_uv_falling |=> (st_r.state == BIAS_AUTO_INACTIVE))
      else $error("autonomous active kept after idle timeout");

   chk_active_gate: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st_r.state != BIAS_ACTIVE) ##1 (st_r.state == BIAS_ACTIVE) |->
      $past(mode == MODE_NORMAL) && $past(supplies_good))
      else $error("active entered without normal mode and good supplies");

   chk_hiz_lowpwr: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      $past(mode != MODE_NORMAL) |-> !st_r.bus.canh_oe && !st_r.bus.canl_oe)
      else $error("driver enabled outside normal mode");

   chk_stuck_block: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      st_r.tx_block |-> !st_r.bus.canh_oe && (st_r.state == BIAS_ACTIVE))
      else $error("blocked transmitter drove the bus");

   chk_timer_restart: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      sync_r.dom |=> (st_r.idle_cnt == '0) && !st_r.timeout)
      else $error("idle timer not restarted by activity");

   chk_rxd_wake: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      low_power && wake_event ##1 low_power |=> !st_r.rxd)
      else $error("wake not shown on receive output");

   // The receive delay relies on the queue never filling; a stall would skew rxd timing.
   chk_fifo_room: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      fifo_in_ready)
      else $error("receive sample queue ran full");

   chk_off_float: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st_r.state == BIAS_OFF) |-> st_r.bus.bias_float && !st_r.bus.bias_mid &&
      !st_r.bus.bias_gnd && !st_r.bus.canh_oe)
      else $error("off state loads the bus");

   chk_active_bias: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st_r.state == BIAS_ACTIVE) |-> st_r.bus.bias_mid && !st_r.bus.bias_gnd)
      else $error("active state not mid biased");

   chk_drv_gate: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      st_r.bus.canh_oe |-> (st_r.state == BIAS_ACTIVE) && !st_r.tx_block && st_r.bus.canl_oe)
      else $error("driver enabled outside active state");

   chk_uv_to_auto: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st_r.state == BIAS_ACTIVE) && uv_falling_any && !sync_r.sup.battery_uv_falling
      |=> (st_r.state == BIAS_AUTO_ACTIVE))
      else $error("supply dip did not leave active state");

   chk_low_short: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st_r.state == BIAS_ACTIVE) && mode_to_low && !uv_falling_any && !st_r.timeout &&
      !sync_r.sup.battery_uv_falling |=> (st_r.state == BIAS_AUTO_ACTIVE))
      else $error("short idle low power entry dropped the bias");

   chk_low_long: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st_r.state == BIAS_ACTIVE) && mode_to_low && !uv_falling_any && st_r.timeout &&
      !sync_r.sup.battery_uv_falling |=> (st_r.state == BIAS_AUTO_INACTIVE))
      else $error("long idle low power entry kept the bias");

   chk_wake_rx_mode: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (mode == MODE_SLEEP) || (mode == MODE_GO_TO_SLEEP) |=> st_r.wake_rx)
      else $error("wake receiver off in sleep modes");

   chk_rxd_oe_supply: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      low_power && !(sync_r.vio && sync_r.vsup) |=> !st_r.rxd_oe)
      else $error("receive output driven without supplies");

   chk_uv_inactive: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (st_r.state == BIAS_AUTO_INACTIVE) && act_mode && uv_falling_any &&
      !sync_r.sup.battery_uv_falling |=> (st_r.state == BIAS_AUTO_ACTIVE))
      else $error("normal mode with supply dip did not raise bias");

endmodule : can_bias_state_control

/* sim/can_ctrl_model.sv */
// Model of the protocol controller and the shared bus beside the bias block.
`timescale 1ns/1ps
module can_ctrl_model
   import can_bias_pkg::*;
#(
   parameter logic [3:0] ANSWER_DLY = 4'h8
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [2:0] mode_req_i,
   input wire logic txd_req_i,
   input wire logic other_dom_i,
   input wire logic answer_en_i,
   input wire logic rxd_i,
   input wire bus_drive_s bus_i,
   output logic [2:0] op_mode_o,
   output logic txd_o,
   output logic bus_dominant_o
);
   logic [3:0] wait_r;
   logic answered_r;

   ////////////////////////////////////////////////////////////////////////////
   // The bus is a wired AND, so any driving node makes it dominant.
   assign bus_dominant_o = (bus_i.canh_oe & bus_i.canl_oe) | other_dom_i;
   assign txd_o = txd_req_i;
   assign op_mode_o = answered_r ? MODE_NORMAL : mode_req_i;

   ////////////////////////////////////////////////////////////////////////////
   // A wake seen on the receive line is answered with normal mode after a delay.
   // A longer delay than the idle timeout would model a controller that is too late.
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wait_r <= 4'h0;
         answered_r <= 1'b0;
      end else if (!answer_en_i) begin
         wait_r <= 4'h0;
         answered_r <= 1'b0;
      end else if (wait_r == ANSWER_DLY) begin
         answered_r <= 1'b1;
      end else if (!rxd_i) begin
         wait_r <= wait_r + 4'h1;
      end
   end

endmodule : can_ctrl_model

/* sim/can_bias_state_control_tb.sv */
// Self-checking bench for the CAN bus-bias state control.
`timescale 1ns/1ps
module can_bias_state_control_tb
   import can_bias_pkg::*;
   ;
   logic core_clk;
   logic rst_b;
   logic [2:0] mode_req;
   logic txd_req;
   logic other_dom;
   logic answer_en;
   logic wake;
   logic vsup;
   logic vio;
   supply_flags_s supply;
   logic [2:0] op_mode;
   logic txd;
   logic bus_dom;
   bias_state_e state;
   bus_drive_s bus;
   logic rxd;
   logic rxd_oe;
   logic block;
   logic wake_rx;
   logic idle_to;
   int miscompares = 0;
   int n_tests = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Design and partner model.
   can_bias_state_control i_dut (
      .core_clk_i(core_clk), .rst_b_i(rst_b), .op_mode_i(op_mode),
      .supply_i(supply), .txd_i(txd), .bus_dominant_i(bus_dom),
      .remote_wake_pattern_i(wake), .vsup_present_i(vsup), .vio_present_i(vio),
      .bias_state_o(state), .bus_o(bus), .rxd_o(rxd), .rxd_oe_o(rxd_oe),
      .tx_stuck_low_block_o(block), .wake_rx_active_o(wake_rx),
      .bus_idle_timeout_o(idle_to)
   );
   can_ctrl_model i_ctrl (
      .core_clk_i(core_clk), .rst_b_i(rst_b), .mode_req_i(mode_req),
      .txd_req_i(txd_req), .other_dom_i(other_dom), .answer_en_i(answer_en),
      .rxd_i(rxd), .bus_i(bus), .op_mode_o(op_mode), .txd_o(txd),
      .bus_dominant_o(bus_dom)
   );

   // Free-running 25 MHz clock.
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared helpers; inputs change 1 ns after the rising edge.
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step

   task automatic check(input logic [1:0] seen, input logic [1:0] expv);
      n_tests++;
      if (seen !== expv) begin
         miscompares++;
         $display("[ERR] %0t saw %0h expected %0h", $time, seen, expv);
      end
   endtask : check

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results

   // Bounded wait for a bias state; running out ends the run.
   task automatic wait_state(input bias_state_e s, input int lim);
      int i;
      for (i = 0; i < lim && state !== s; i++) step(1);
      if (state !== s) begin
         miscompares++;
         $display("[ERR] %0t state wait ran out", $time);
         results();
      end
   endtask : wait_state

   task automatic pulse_dom();
      other_dom = 1'b1;
      step(2);
      other_dom = 1'b0;
   endtask : pulse_dom

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic t_power_up();
      check(state, BIAS_OFF);
      check(2'(bus.bias_float), 2'h1);
      supply.battery_uv_rising = 1'b1;
      wait_state(BIAS_AUTO_INACTIVE, 10);
      check(state, BIAS_AUTO_INACTIVE);
      check(2'(bus.bias_gnd), 2'h1);
      check(2'(bus.bias_mid), 2'h0);
   endtask : t_power_up

   // The model answers the wake with normal mode, so no fall-back happens.
   task automatic t_wake_answer();
      mode_req = MODE_STANDBY;
      answer_en = 1'b1;
      wake = 1'b1;
      wait_state(BIAS_AUTO_ACTIVE, 10);
      check(2'(bus.bias_mid), 2'h1);
      wait_state(BIAS_ACTIVE, 60);
      check(state, BIAS_ACTIVE);
      check(2'(bus.bias_mid), 2'h1);
      mode_req = MODE_NORMAL;
      answer_en = 1'b0;
      wake = 1'b0;
      step(2);
   endtask : t_wake_answer

   task automatic t_traffic();
      txd_req = 1'b0;
      step(6);
      check({bus.canh_oe, bus.canl_oe}, 2'h3);
      check({bus.canh_o, bus.canl_o}, 2'h2);
      step(8);
      check(2'(rxd), 2'h0);
      txd_req = 1'b1;
      step(6);
      check({bus.canh_oe, bus.canl_oe}, 2'h0);
      step(8);
      check(2'(rxd), 2'h1);
      mode_req = MODE_SILENT;
      txd_req = 1'b0;
      step(6);
      check({bus.canh_oe, bus.canl_oe}, 2'h0);
      other_dom = 1'b1;
      step(8);
      check(2'(rxd), 2'h0);
      other_dom = 1'b0;
      txd_req = 1'b1;
      mode_req = MODE_NORMAL;
      step(8);
   endtask : t_traffic

   // Short idle into standby, then a stuck-low transmit input on wake-up.
   task automatic t_stuck_low();
      pulse_dom();
      mode_req = MODE_STANDBY;
      wait_state(BIAS_AUTO_ACTIVE, 10);
      check(state, BIAS_AUTO_ACTIVE);
      txd_req = 1'b0;
      step(6);
      check({bus.canh_oe, bus.canl_oe}, 2'h0);
      mode_req = MODE_NORMAL;
      wait_state(BIAS_ACTIVE, 10);
      step(6);
      check(2'(block), 2'h1);
      check({bus.canh_oe, bus.canl_oe}, 2'h0);
      txd_req = 1'b1;
      supply.io_supply_uv_falling = 1'b1;
      wait_state(BIAS_AUTO_ACTIVE, 10);
      check(state, BIAS_AUTO_ACTIVE);
      supply.io_supply_uv_falling = 1'b0;
      wait_state(BIAS_ACTIVE, 10);
      check(2'(block), 2'h0);
   endtask : t_stuck_low

   // Long silence in standby, then an unanswered wake that times out.
   task automatic t_idle_timeout();
      pulse_dom();
      mode_req = MODE_STANDBY;
      step(24000);
      check(state, BIAS_AUTO_ACTIVE);
      wait_state(BIAS_AUTO_INACTIVE, 2000);
      check(2'(idle_to), 2'h1);
      pulse_dom();
      wake = 1'b1;
      step(3);
      check(state, BIAS_AUTO_ACTIVE);
      wait_state(BIAS_AUTO_ACTIVE, 10);
      check(2'(bus.bias_mid), 2'h1);
      wake = 1'b0;
      step(8);
      check(2'(rxd), 2'h0);
      step(24000);
      check(state, BIAS_AUTO_ACTIVE);
      wait_state(BIAS_AUTO_INACTIVE, 2000);
      check(state, BIAS_AUTO_INACTIVE);
   endtask : t_idle_timeout

   task automatic t_uv_normal();
      supply.core_supply_uv_falling = 1'b1;
      mode_req = MODE_NORMAL;
      wait_state(BIAS_AUTO_ACTIVE, 10);
      check(state, BIAS_AUTO_ACTIVE);
      step(20);
      check(state, BIAS_AUTO_ACTIVE);
      supply.core_supply_uv_falling = 1'b0;
      wait_state(BIAS_ACTIVE, 10);
      check(state, BIAS_ACTIVE);
   endtask : t_uv_normal

   task automatic t_sleep_off();
      mode_req = MODE_GO_TO_SLEEP;
      step(6);
      check(2'(wake_rx), 2'h1);
      check(state, BIAS_AUTO_INACTIVE);
      mode_req = MODE_SLEEP;
      vio = 1'b0;
      step(6);
      check(2'(rxd_oe), 2'h0);
      vio = 1'b1;
      supply.battery_uv_falling = 1'b1;
      wait_state(BIAS_OFF, 10);
      check(2'(bus.bias_float), 2'h1);
      check({bus.canh_oe, bus.canl_oe}, 2'h0);
   endtask : t_sleep_off

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence: core and io supplies good, battery still low at reset.
   initial begin
      rst_b = 1'b0;
      mode_req = MODE_STANDBY;
      txd_req = 1'b1;
      other_dom = 1'b0;
      answer_en = 1'b0;
      wake = 1'b0;
      vsup = 1'b1;
      vio = 1'b1;
      supply = '0;
      supply.core_supply_uv_rising = 1'b1;
      supply.io_supply_uv_rising = 1'b1;
      step(5);
      rst_b = 1'b1;
      step(2);
      t_power_up();
      t_wake_answer();
      t_traffic();
      t_stuck_low();
      t_idle_timeout();
      t_uv_normal();
      t_sleep_off();
      results();
   end

endmodule : can_bias_state_control_tb
